// [design/scrs_map.svh]
// constants for the system channel relay selector
`ifndef SCRS_MAP_SVH
`define SCRS_MAP_SVH
`define SCRS_NUM_SLOTS      2
`define SCRS_NUM_RELAYS     25
`define SCRS_MEAS_CHANS     7'd20
`define SCRS_HALF_CHANS     7'd10
`define SCRS_RLY_POLE       5'd23
`define SCRS_RLY_SENSE      5'd24
`define SCRS_RLY_INPUT      5'd25
`define SCRS_MSG_NS         500
`define SCRS_MSG_CYC        ((`SCRS_MSG_NS + 4) / 5)
`define SCRS_ID_NS          1000
`define SCRS_ID_CYC         ((`SCRS_ID_NS + 4) / 5)
`endif

// [design/scrs_pkg.sv]
// types for the system channel relay selector
package scrs_pkg;
   typedef enum logic [1:0] {
      SCRS_MT_EMPTY = 2'h0,
      SCRS_MT_MEAS  = 2'h1,
      SCRS_MT_NOMEAS = 2'h2
   } scrs_mtype_t;

   typedef enum logic [1:0] {
      SCRS_ST_IDENT = 2'h0,
      SCRS_ST_IDLE  = 2'h1,
      SCRS_ST_CLOSE = 2'h3,
      SCRS_ST_OPEN  = 2'h2
   } scrs_state_t;

   // slot digit 1 or 2, channel 1..20 (1..10 four-wire); slot 0 means none
   typedef struct packed {
      logic [1:0] slot;
      logic [6:0] chan;
   } scrs_code_t;

   typedef struct packed {
      logic       valid;
      logic       four_wire;
      scrs_code_t code;
   } scrs_req_t;
endpackage : scrs_pkg

// [design/scrs_selector.sv]
// system channel relay selector top module
`timescale 1ns/1ps
`default_nettype none
`include "scrs_map.svh"
module scrs_selector #(
   parameter int MSG_CYC = `SCRS_MSG_CYC,
   parameter int ID_CYC  = `SCRS_ID_CYC
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_b_i,
   input  wire scrs_pkg::scrs_mtype_t      slot1_real_i,
   input  wire scrs_pkg::scrs_mtype_t      slot2_real_i,
   input  wire logic                       four_wire_i,
   input  wire scrs_pkg::scrs_req_t        direct_req_i,
   input  wire logic                       direct_remote_i,
   input  wire logic                       next_i,
   input  wire logic                       prev_i,
   input  wire logic                       open_all_i,
   input  wire logic                       virtual_module_assign_cmd_i,
   input  wire logic                       assign_remote_i,
   input  wire logic [1:0]                 assign_slot_i,
   input  wire scrs_pkg::scrs_mtype_t      assign_type_i,
   output logic [`SCRS_NUM_RELAYS:1]       slot1_relays_o,
   output logic [`SCRS_NUM_RELAYS:1]       slot2_relays_o,
   output scrs_pkg::scrs_code_t            slot_channel_code_o,
   output logic                            chan_valid_o,
   output logic                            no_module_indication_o,
   output logic                            no_measure_module_indication_o,
   output logic                            invalid_channel_indication_o,
   output logic                            assign_reject_o,
   output logic                            ident_active_o
);

   typedef struct packed {
      scrs_pkg::scrs_state_t  st;
      scrs_pkg::scrs_mtype_t  virt1;
      scrs_pkg::scrs_mtype_t  virt2;
      scrs_pkg::scrs_code_t   sys;
      logic                   sys_fw;
      scrs_pkg::scrs_code_t   pend;
      logic                   pend_fw;
      logic [`SCRS_NUM_RELAYS:1] r1;
      logic [`SCRS_NUM_RELAYS:1] r2;
      logic                   nomod;
      logic                   nomeas;
      logic                   inval;
      logic                   arej;
      logic [15:0]            msg_cnt;
      logic [15:0]            id_cnt;
      logic                   cv;
      logic                   ident;
   } scrs_state_all_t;

   scrs_state_all_t s_q;
   scrs_state_all_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_meas(input scrs_pkg::scrs_mtype_t t);
      is_meas = (t == scrs_pkg::SCRS_MT_MEAS);
   endfunction

   // a legal system channel under the given wiring mode
   function automatic logic chan_ok(input scrs_pkg::scrs_code_t c, input logic fw,
                                    input logic m1, input logic m2);
      logic slot_meas;
      logic [6:0] top;
      slot_meas = (c.slot == 2'd1) ? m1 : ((c.slot == 2'd2) ? m2 : 1'b0);
      top = fw ? `SCRS_HALF_CHANS : `SCRS_MEAS_CHANS;
      chan_ok = slot_meas && (c.chan >= 7'd1) && (c.chan <= top);
   endfunction

   // relay image of a slot for one selection
   function automatic logic [`SCRS_NUM_RELAYS:1] relay_image(input scrs_pkg::scrs_code_t c,
                                                             input logic fw,
                                                             input logic [1:0] slot);
      logic [`SCRS_NUM_RELAYS:1] img;
      img = '0;
      if (c.slot == slot) begin
         img[c.chan[4:0]] = 1'b1;
         img[`SCRS_RLY_INPUT] = 1'b1;
         if (fw) begin
            img[5'(c.chan + `SCRS_HALF_CHANS)] = 1'b1;
            img[`SCRS_RLY_SENSE] = 1'b1;
            img[`SCRS_RLY_POLE]  = 1'b1;
         end
      end
      relay_image = img;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   scrs_pkg::scrs_mtype_t eff1;
   scrs_pkg::scrs_mtype_t eff2;
   logic                  m1;
   logic                  m2;
   logic [6:0]            top_c;
   scrs_pkg::scrs_code_t  step_c;
   logic                  want;

   always_comb begin
      s_d = s_q;
      // virtual module counts as if installed
      eff1 = (slot1_real_i != scrs_pkg::SCRS_MT_EMPTY) ? slot1_real_i : s_q.virt1;
      eff2 = (slot2_real_i != scrs_pkg::SCRS_MT_EMPTY) ? slot2_real_i : s_q.virt2;
      m1 = is_meas(eff1);
      m2 = is_meas(eff2);
      top_c = four_wire_i ? `SCRS_HALF_CHANS : `SCRS_MEAS_CHANS;
      step_c = '0;
      want = 1'b0;
      s_d.arej = 1'b0;
      if (s_q.msg_cnt != 16'h0000) begin
         s_d.msg_cnt = s_q.msg_cnt - 16'h0001;
      end else begin
         s_d.nomod  = 1'b0;
         s_d.nomeas = 1'b0;
         s_d.inval  = 1'b0;
      end
      if (virtual_module_assign_cmd_i) begin
         // remote path only, empty real slot only
         if (assign_remote_i && assign_slot_i == 2'd1 &&
             slot1_real_i == scrs_pkg::SCRS_MT_EMPTY) begin
            s_d.virt1 = assign_type_i;
         end else if (assign_remote_i && assign_slot_i == 2'd2 &&
                      slot2_real_i == scrs_pkg::SCRS_MT_EMPTY) begin
            s_d.virt2 = assign_type_i;
         end else begin
            s_d.arej = 1'b1;
         end
      end
      unique case (s_q.st)
         scrs_pkg::SCRS_ST_IDENT: begin
            // identity display window after reset
            if (s_q.id_cnt == 16'h0000) begin
               s_d.st = scrs_pkg::SCRS_ST_IDLE;
            end else begin
               s_d.id_cnt = s_q.id_cnt - 16'h0001;
            end
         end
         scrs_pkg::SCRS_ST_IDLE: begin
            if (open_all_i) begin
               s_d.sys = '0;
               s_d.r1  = '0;
               s_d.r2  = '0;
            end else if (next_i || prev_i) begin
               if (eff1 == scrs_pkg::SCRS_MT_EMPTY && eff2 == scrs_pkg::SCRS_MT_EMPTY) begin
                  s_d.nomod = 1'b1;
                  s_d.msg_cnt = 16'(MSG_CYC);
               end else if (!m1 && !m2) begin
                  s_d.nomeas = 1'b1;
                  s_d.msg_cnt = 16'(MSG_CYC);
               end else begin
                  // walk the ordered list; the none position sits past both ends
                  if (next_i) begin
                     if (s_q.sys.slot == 2'd0) begin
                        step_c = m1 ? scrs_pkg::scrs_code_t'{2'h1, 7'h01}
                                    : scrs_pkg::scrs_code_t'{2'h2, 7'h01};
                     end else if (s_q.sys.chan < top_c) begin
                        step_c = '{s_q.sys.slot, 7'(s_q.sys.chan + 7'd1)};
                     end else if (s_q.sys.slot == 2'd1 && m2) begin
                        step_c = '{2'd2, 7'd1};
                     end
                  end else begin
                     if (s_q.sys.slot == 2'd0) begin
                        step_c = m2 ? scrs_pkg::scrs_code_t'{2'h2, top_c}
                                    : scrs_pkg::scrs_code_t'{2'h1, top_c};
                     end else if (s_q.sys.chan > 7'd1) begin
                        step_c = '{s_q.sys.slot, 7'(s_q.sys.chan - 7'd1)};
                     end else if (s_q.sys.slot == 2'd2 && m1) begin
                        step_c = '{2'd1, top_c};
                     end
                  end
                  if (step_c.slot != 2'd0 && !chan_ok(step_c, four_wire_i, m1, m2)) begin
                     step_c = '0;
                  end
                  want = 1'b1;
               end
            end else if (direct_req_i.valid) begin
               if (chan_ok(direct_req_i.code, four_wire_i, m1, m2)) begin
                  step_c = direct_req_i.code;
                  want = 1'b1;
               end else if (direct_remote_i && direct_req_i.code.slot != 2'd0 &&
                            (direct_req_i.code.slot == 2'd1 ?
                             eff1 == scrs_pkg::SCRS_MT_NOMEAS :
                             eff2 == scrs_pkg::SCRS_MT_NOMEAS)) begin
                  s_d.inval = 1'b1;
                  s_d.msg_cnt = 16'(MSG_CYC);
               end else begin
                  // relays untouched on refusal
                  s_d.inval = 1'b1;
                  s_d.msg_cnt = 16'(MSG_CYC);
               end
            end
            if (want) begin
               // open everything first, close on the next cycle
               s_d.r1 = '0;
               s_d.r2 = '0;
               s_d.sys = '0;
               s_d.pend = step_c;
               s_d.pend_fw = four_wire_i;
               s_d.st = (step_c.slot == 2'd0) ? scrs_pkg::SCRS_ST_IDLE
                                              : scrs_pkg::SCRS_ST_CLOSE;
            end
         end
         scrs_pkg::SCRS_ST_CLOSE: begin
            s_d.r1 = relay_image(s_q.pend, s_q.pend_fw, 2'd1);
            s_d.r2 = relay_image(s_q.pend, s_q.pend_fw, 2'd2);
            s_d.sys = s_q.pend;
            s_d.sys_fw = s_q.pend_fw;
            s_d.st = scrs_pkg::SCRS_ST_OPEN;
         end
         scrs_pkg::SCRS_ST_OPEN: begin
            s_d.st = scrs_pkg::SCRS_ST_IDLE;
         end
      endcase
      // flopped copies of derived outputs
      s_d.cv    = (s_d.sys.slot != 2'h0);
      s_d.ident = (s_d.st == scrs_pkg::SCRS_ST_IDENT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_q <= '0; // virtual modules lost
         s_q.st <= scrs_pkg::SCRS_ST_IDENT;
         s_q.virt1 <= scrs_pkg::SCRS_MT_EMPTY;
         s_q.virt2 <= scrs_pkg::SCRS_MT_EMPTY;
         s_q.id_cnt <= 16'(ID_CYC);
         s_q.ident <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign slot1_relays_o                 = s_q.r1;
   assign slot2_relays_o                 = s_q.r2;
   assign slot_channel_code_o            = s_q.sys;
   assign chan_valid_o                   = s_q.cv;
   assign no_module_indication_o         = s_q.nomod;
   assign no_measure_module_indication_o = s_q.nomeas;
   assign invalid_channel_indication_o   = s_q.inval;
   assign assign_reject_o                = s_q.arej;
   assign ident_active_o                 = s_q.ident;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_input_iso: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot == 2'd1) |-> s_q.r1[`SCRS_RLY_INPUT])
      else $error("input isolation relay open with channel selected");
   a_fw_sense: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot == 2'd1 && s_q.sys_fw) |->
      (s_q.r1[`SCRS_RLY_SENSE] && s_q.r1[`SCRS_RLY_POLE] && s_q.r1[s_q.sys.chan[4:0] + 5'd10]))
      else $error("four-wire relays missing");
   a_fw_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot != 2'd0 && s_q.sys_fw) |-> (s_q.sys.chan <= 7'd10))
      else $error("four-wire system channel out of range");
   a_open_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_CLOSE) |-> (s_q.r1 == '0 && s_q.r2 == '0))
      else $error("close issued before open");
   a_one_slot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !(|s_q.r1[20:1] && |s_q.r2[20:1]))
      else $error("channels closed in both slots");
   a_none_open: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot == 2'd0 && s_q.st == scrs_pkg::SCRS_ST_IDLE) |->
      (s_q.r1 == '0 && s_q.r2 == '0))
      else $error("relays closed without system channel");
   a_nomod_ind: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && !open_all_i && next_i &&
       eff1 == scrs_pkg::SCRS_MT_EMPTY && eff2 == scrs_pkg::SCRS_MT_EMPTY)
      |=> (s_q.nomod && s_q.sys == $past(s_q.sys)))
      else $error("no-module indication missing");
   a_nomeas_ind: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && !open_all_i && (next_i || prev_i) &&
       !m1 && !m2 && (eff1 != scrs_pkg::SCRS_MT_EMPTY || eff2 != scrs_pkg::SCRS_MT_EMPTY))
      |=> s_q.nomeas)
      else $error("no-measurement indication missing");
   a_local_assign: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (virtual_module_assign_cmd_i && !assign_remote_i) |=> (s_q.arej && $stable(s_q.virt1)))
      else $error("front panel created virtual module");
   // selection path
   a_input_iso_s2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot == 2'h2) |-> s_q.r2[`SCRS_RLY_INPUT])
      else $error("slot two input isolation relay open with channel selected");
   a_fw_sense_s2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot == 2'h2 && s_q.sys_fw) |->
      (s_q.r2[`SCRS_RLY_SENSE] && s_q.r2[`SCRS_RLY_POLE] && s_q.r2[s_q.sys.chan[4:0] + 5'h0A]))
      else $error("slot two four-wire relays missing");
   a_code_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.sys.slot != 2'h0) |->
      (s_q.sys.slot <= 2'h2 && s_q.sys.chan >= 7'h01 && s_q.sys.chan <= `SCRS_MEAS_CHANS))
      else $error("system channel code out of range");
   a_valid_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      chan_valid_o == (s_q.sys.slot != 2'h0))
      else $error("channel valid flag disagrees with system channel");
   a_open_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && want) |=>
      (s_q.r1 == '0 && s_q.r2 == '0 && s_q.sys == '0))
      else $error("previous channel not opened first");
   a_close_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_CLOSE) |=>
      (s_q.sys == $past(s_q.pend) && s_q.st == scrs_pkg::SCRS_ST_OPEN))
      else $error("new channel not taken as system channel");
   a_step_next: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && !open_all_i && next_i && m1 &&
       s_q.sys.slot == 2'h1 && s_q.sys.chan >= 7'h01 && s_q.sys.chan < top_c) |->
      ##2 (s_q.sys.slot == 2'h1 && s_q.sys.chan == 7'($past(s_q.sys.chan, 2) + 7'h01)))
      else $error("next key did not reach following channel");
   a_step_end: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && !open_all_i && next_i && m1 &&
       s_q.sys.slot == 2'h2 && s_q.sys.chan >= top_c) |=>
      (s_q.sys == '0 && s_q.r1 == '0 && s_q.r2 == '0))
      else $error("stepping past last channel left relays closed");
   // refusals, virtual modules and identity
   a_refuse_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && !open_all_i && !next_i && !prev_i &&
       direct_req_i.valid && !chan_ok(direct_req_i.code, four_wire_i, m1, m2)) |=>
      ($stable(s_q.r1) && $stable(s_q.r2) && $stable(s_q.sys) && s_q.inval))
      else $error("refused selection changed relays");
   a_nomod_prev: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDLE && !open_all_i && prev_i &&
       eff1 == scrs_pkg::SCRS_MT_EMPTY && eff2 == scrs_pkg::SCRS_MT_EMPTY)
      |=> (s_q.nomod && $stable(s_q.r1) && $stable(s_q.r2)))
      else $error("no-module indication missing on previous key");
   a_virt_taken: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (virtual_module_assign_cmd_i && assign_slot_i == 2'h1 &&
       slot1_real_i != scrs_pkg::SCRS_MT_EMPTY) |=> (s_q.arej && $stable(s_q.virt1)))
      else $error("virtual module placed over installed module");
   a_ident_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (s_q.st == scrs_pkg::SCRS_ST_IDENT) |->
      (ident_active_o && s_q.r1 == '0 && s_q.r2 == '0 && s_q.sys == '0))
      else $error("selection made during identity window");
   c_select: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      s_q.st == scrs_pkg::SCRS_ST_CLOSE ##1 chan_valid_o);
   c_fw: cover property (@(posedge clk_i) disable iff (!rst_b_i) chan_valid_o && s_q.sys_fw);
   c_inval: cover property (@(posedge clk_i) disable iff (!rst_b_i) s_q.inval);
   c_virt: cover property (@(posedge clk_i) disable iff (!rst_b_i) s_q.virt2 != 2'h0);
   c_nomod: cover property (@(posedge clk_i) disable iff (!rst_b_i) s_q.nomod);

endmodule : scrs_selector
`default_nettype wire

// [tb/scrs_keys.sv]
// key and remote command source model for the selector
`timescale 1ns/1ps
`default_nettype none
module scrs_keys (
   input  wire logic             clk_i,
   output scrs_pkg::scrs_req_t   req_o,
   output logic                  remote_o,
   output logic                  next_o,
   output logic                  prev_o,
   output logic                  open_all_o,
   output logic                  assign_o,
   output logic [1:0]            aslot_o,
   output scrs_pkg::scrs_mtype_t atype_o
);
   initial begin
      req_o = '0;
      remote_o = 1'b0;
      {next_o, prev_o, open_all_o, assign_o} = 4'h0;
      aslot_o = 2'h0;
      atype_o = scrs_pkg::SCRS_MT_EMPTY;
   end
   // kind: 0 next, 1 prev, 2 open all, 3 direct, 4 virtual assign
   task automatic press(input int k, input logic [1:0] sl, input logic [6:0] ch,
                        input logic rem, input scrs_pkg::scrs_mtype_t mt);
      @(negedge clk_i);
      remote_o = rem;
      case (k)
         0: next_o = 1'b1;
         1: prev_o = 1'b1;
         2: open_all_o = 1'b1;
         3: begin
            req_o.code.slot = sl;
            req_o.code.chan = ch;
            req_o.valid = 1'b1;
         end
         default: begin
            assign_o = 1'b1;
            aslot_o = sl;
            atype_o = mt;
         end
      endcase
      @(negedge clk_i);
      {next_o, prev_o, open_all_o, assign_o} = 4'h0;
      req_o.valid = 1'b0;
      // released lines carry no stale value
      req_o.code = ~req_o.code;
      aslot_o = ~aslot_o;
      remote_o = ~remote_o;
   endtask
endmodule // scrs_keys
`default_nettype wire

// [tb/scrs_selector_bench.sv]
// self-checking testbench for the system channel relay selector
`timescale 1ns/1ps
`default_nettype none
module scrs_selector_bench;
   localparam int MSG = 2;
   localparam int IDC = 3;
   logic                  clk_i;
   logic                  rst_b_i;
   logic                  fw;
   scrs_pkg::scrs_mtype_t s1, s2, atype;
   scrs_pkg::scrs_req_t   req;
   scrs_pkg::scrs_code_t  code;
   logic                  rem, nx, pv, oa, asg, cv, nmod, nmeas, inv, arej, ident;
   logic [1:0]            aslot;
   logic [25:1]           r1, r2;
   int                    miscompares = 0;
   int                    checks = 0;

   scrs_keys k (.clk_i(clk_i), .req_o(req), .remote_o(rem), .next_o(nx), .prev_o(pv),
      .open_all_o(oa), .assign_o(asg), .aslot_o(aslot), .atype_o(atype));

   scrs_selector #(.MSG_CYC(MSG), .ID_CYC(IDC)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .slot1_real_i(s1), .slot2_real_i(s2), .four_wire_i(fw), .direct_req_i(req),
      .direct_remote_i(rem), .next_i(nx), .prev_i(pv), .open_all_i(oa),
      .virtual_module_assign_cmd_i(asg), .assign_remote_i(rem), .assign_slot_i(aslot),
      .assign_type_i(atype), .slot1_relays_o(r1), .slot2_relays_o(r2),
      .slot_channel_code_o(code), .chan_valid_o(cv), .no_module_indication_o(nmod),
      .no_measure_module_indication_o(nmeas), .invalid_channel_indication_o(inv),
      .assign_reject_o(arej), .ident_active_o(ident));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // expected relay image for a system channel
   function automatic logic [25:1] img(input int ch, input logic four);
      img = '0;
      if (ch > 0) begin
         img[ch] = 1'b1;
         img[25] = 1'b1;
         if (four) begin
            img[ch + 10] = 1'b1;
            img[23] = 1'b1;
            img[24] = 1'b1;
         end
      end
   endfunction

   function automatic logic flag(input int w);
      case (w)
         0: flag = nmod;
         1: flag = nmeas;
         2: flag = inv;
         default: flag = arej;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic do_reset;
      int n;
      n = 0;
      @(negedge clk_i);
      rst_b_i = 1'b0;
      repeat (12) @(negedge clk_i);
      chk("reset slot1 relays", 32'h0, 32'(r1));
      chk("reset slot2 relays", 32'h0, 32'(r2));
      chk("reset code", 32'h0, 32'(code));
      chk("ident at reset", 32'h1, 32'(ident));
      rst_b_i = 1'b1;
      while (ident === 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      chk("ident cycles", IDC + 1, n);
   endtask

   // selection request, then relays, code and open-before-close gap
   task automatic sel(input int kd, input logic [1:0] sl, input logic [6:0] ch,
                      input logic [1:0] es, input int ech, input logic gap);
      logic seen;
      seen = 1'b0;
      k.press(kd, sl, ch, 1'b0, scrs_pkg::SCRS_MT_MEAS);
      repeat (5) begin
         if (r1 === '0 && r2 === '0) seen = 1'b1;
         @(negedge clk_i);
      end
      chk("slot1 relays", 32'(img(es == 2'h1 ? ech : 0, fw)), 32'(r1));
      chk("slot2 relays", 32'(img(es == 2'h2 ? ech : 0, fw)), 32'(r2));
      chk("channel code", 32'({es, 7'(ech)}), 32'(code));
      chk("channel valid", 32'(es != 2'h0), 32'(cv));
      if (gap) chk("open before close", 32'h1, 32'(seen));
   endtask

   // refused or signalled request: flag pulse length, relays untouched
   task automatic ind(input int kd, input logic [1:0] sl, input logic [6:0] ch,
                      input logic rm, input int w, input int len, input logic [25:1] e1);
      int hi;
      hi = 0;
      k.press(kd, sl, ch, rm, scrs_pkg::SCRS_MT_MEAS);
      repeat (6) begin
         if (flag(w) === 1'b1) hi++;
         @(negedge clk_i);
      end
      chk("indication cycles", len, hi);
      chk("slot1 relays kept", 32'(e1), 32'(r1));
      chk("slot2 relays kept", 32'h0, 32'(r2));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b_i = 1'b0;
      fw = 1'b0;
      s1 = scrs_pkg::SCRS_MT_EMPTY;
      s2 = scrs_pkg::SCRS_MT_EMPTY;
      do_reset();
      ind(0, 2'h0, 7'h00, 1'b0, 0, MSG + 1, '0);
      ind(1, 2'h0, 7'h00, 1'b0, 0, MSG + 1, '0);
      s1 = scrs_pkg::SCRS_MT_NOMEAS;
      ind(1, 2'h0, 7'h00, 1'b0, 1, MSG + 1, '0);
      s1 = scrs_pkg::SCRS_MT_MEAS;
      sel(0, 2'h0, 7'h00, 2'h1, 1, 1'b0);
      sel(0, 2'h0, 7'h00, 2'h1, 2, 1'b1);
      sel(3, 2'h1, 7'h05, 2'h1, 5, 1'b1);
      fw = 1'b1;
      sel(3, 2'h1, 7'h03, 2'h1, 3, 1'b1);
      ind(3, 2'h1, 7'h0C, 1'b1, 2, MSG + 1, img(3, 1'b1));
      ind(3, 2'h1, 7'h15, 1'b0, 2, MSG + 1, img(3, 1'b1));
      sel(3, 2'h1, 7'h0A, 2'h1, 10, 1'b1);
      sel(0, 2'h0, 7'h00, 2'h0, 0, 1'b0);
      sel(1, 2'h0, 7'h00, 2'h1, 10, 1'b0);
      sel(2, 2'h0, 7'h00, 2'h0, 0, 1'b0);
      fw = 1'b0;
      s2 = scrs_pkg::SCRS_MT_NOMEAS;
      ind(3, 2'h2, 7'h01, 1'b0, 2, MSG + 1, '0);
      ind(3, 2'h2, 7'h01, 1'b1, 2, MSG + 1, '0);
      s2 = scrs_pkg::SCRS_MT_EMPTY;
      ind(4, 2'h2, 7'h00, 1'b0, 3, 1, '0);
      ind(4, 2'h1, 7'h00, 1'b1, 3, 1, '0);
      ind(4, 2'h2, 7'h00, 1'b1, 3, 0, '0);
      sel(1, 2'h0, 7'h00, 2'h2, 20, 1'b0);
      sel(0, 2'h0, 7'h00, 2'h0, 0, 1'b0);
      do_reset();
      sel(1, 2'h0, 7'h00, 2'h1, 20, 1'b0);
      end_of_test();
   end

   initial begin
      #5000;
      miscompares++;
      end_of_test();
   end
endmodule // scrs_selector_bench
`default_nettype wire
